// ### logic/lvdsk_deskew.sv
// LVDS lane deskew, alignment status, sync pin roles and APB register file
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module lvdsk_deskew
  import lvdsk_pkg::*;
#(
  parameter int LANES = LVDSK_LANES
) (
  input wire logic pclk, // System clock, 25 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic link_clk, // LVDS link clock pin
  input wire logic [LANES-1:0] lane_in, // LVDS data lanes
  input wire logic enable_or_vertical_sync_pin, // Shared enable / vsync pin
  input wire logic horizontal_sync_or_align_pin, // Shared hsync / align pin
  output logic [LANES-1:0] lane_out, // Deskewed lane bits
  output logic lane_valid, // Pulse when lane_out updates
  output logic enable_out, // Enable level from the shared pin
  output logic vsync_out, // Vertical sync from the shared pin
  output logic hsync_out, // Horizontal sync from the shared pin
  output logic align_out, // Alignment from the shared pin
  output logic irq // Level interrupt
);

  typedef struct packed {
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_p;
    logic [LANES-1:0] lane_s1;
    logic [LANES-1:0] lane_s2;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [LANES-1:0][LVDSK_SKEW_W-1:0] skew;
    logic [1:0] mode;
    logic [7:0] sync_mode;
    logic [LANES-1:0] early;
    logic [LANES-1:0] late_ok;
    logic [LVDSK_IRQ_W-1:0] irq_stat;
    logic [LVDSK_IRQ_W-1:0] irq_en;
    logic [LANES-1:0] lane_out;
    logic lane_valid;
    logic enable_out;
    logic vsync_out;
    logic hsync_out;
    logic align_out;
    logic [31:0] prdata;
  } lvdsk_state_type;

  lvdsk_state_type q;
  lvdsk_state_type d;

  logic [LANES-1:0][LVDSK_DLY_W-1:0] dly;
  logic [LANES-1:0] smp;
  logic [LANES-1:0] older;
  logic [LANES-1:0] newer;

  // Per lane: pick the setting, map it to delay units, run the tap line
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [LVDSK_SKEW_W-1:0] sel_skew;
    assign sel_skew = (q.mode == LVDSK_MODE_OVERRIDE) ? q.skew[0] : q.skew[i];
    assign dly[i] = (|sel_skew[LVDSK_SKEW_W-1:LVDSK_DLY_W]) ? LVDSK_DLY_MAX : sel_skew[LVDSK_DLY_W-1:0];

    lvdsk_lane_delay #(
      .TAPS(LVDSK_TAPS)
    ) u_delay (
      .pclk(pclk),
      .presetn(presetn),
      .din(q.lane_s2[i]),
      .delay(dly[i]),
      .smp(smp[i]),
      .older(older[i]),
      .newer(newer[i])
    );
  end

  // Address decode helpers
  logic [LVDSK_IDX_W-1:0] idx;
  logic [LVDSK_IDX_W-1:0] skew_off;
  logic is_skew;
  logic mapped;
  logic setup_ph;
  logic access_ph;
  logic link_edge;
  logic [1:0] skew_lane;
  logic skew_hi;

  assign idx = paddr[LVDSK_ADDR_LSB +: LVDSK_IDX_W];
  assign skew_off = idx - LVDSK_IDX_SKEW_BASE;
  assign is_skew = (idx >= LVDSK_IDX_SKEW_BASE) && (idx < LVDSK_IDX_SKEW_LAST);
  assign skew_lane = skew_off[2:1];
  assign skew_hi = ~skew_off[0];
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign link_edge = q.lclk_s2 & ~q.lclk_p;
  assign mapped = is_skew || (idx == LVDSK_IDX_EARLY) || (idx == LVDSK_IDX_LATE) ||
                  (idx == LVDSK_IDX_SYNC) || (idx == LVDSK_IDX_MODE) || (idx == LVDSK_IDX_IRQ_STAT) ||
                  (idx == LVDSK_IDX_IRQ_CLR) || (idx == LVDSK_IDX_IRQ_EN);

  // Next state for the whole block
  always_comb begin
    logic [LVDSK_IRQ_W-1:0] evt;
    logic [LVDSK_IRQ_W-1:0] clr;
    logic wr;
    lvdsk_en_role_type role;
    evt = '0;
    clr = '0;
    wr = access_ph & pwrite & mapped;
    role = lvdsk_en_role_type'(q.sync_mode[LVDSK_EN_ROLE_LSB +: 2]);
    d = q;

    // Two-flop synchronisers for every pin, plus an edge-detect stage on the link clock
    d.lclk_s1 = link_clk;
    d.lclk_s2 = q.lclk_s1;
    d.lclk_p = q.lclk_s2;
    d.lane_s1 = lane_in;
    d.lane_s2 = q.lane_s1;
    d.pin_s1 = {horizontal_sync_or_align_pin, enable_or_vertical_sync_pin};
    d.pin_s2 = q.pin_s1;

    // On each link clock rising edge take the deskewed bit and judge the sample point
    d.lane_valid = link_edge;
    if (link_edge) begin
      d.lane_out = smp;
      // readout MSB, transition just before sampling
      d.early = smp ^ older;
      for (int i = 0; i < LANES; i++) begin
        d.late_ok[i] = (dly[i] == '0) | (smp[i] == newer[i]);
      end
      evt[LVDSK_IRQ_EARLY] = |d.early;
      evt[LVDSK_IRQ_LATE] = ~&d.late_ok;
    end

    // shared enable / vsync pin role
    unique case (role)
      LVDSK_EN_ENABLE: begin
        d.enable_out = q.pin_s2[0];
        d.vsync_out = 1'b0;
      end
      LVDSK_EN_VSYNC: begin
        d.enable_out = 1'b0;
        d.vsync_out = q.pin_s2[0];
      end
      default: begin
        d.enable_out = 1'b0;
        d.vsync_out = 1'b0;
      end
    endcase

    d.hsync_out = q.pin_s2[1] & ~q.sync_mode[LVDSK_HS_ROLE_BIT];
    d.align_out = q.pin_s2[1] & q.sync_mode[LVDSK_HS_ROLE_BIT];

    // Register writes take effect at the access-phase edge
    if (wr) begin
      if (is_skew) begin
        if (skew_hi) begin
          d.skew[skew_lane][15:8] = pwdata[7:0];
        end else begin
          d.skew[skew_lane][7:0] = pwdata[7:0];
        end
      end
      if (idx == LVDSK_IDX_SYNC) begin
        d.sync_mode = pwdata[7:0];
      end
      if (idx == LVDSK_IDX_MODE) begin
        d.mode = pwdata[1:0];
      end
      if (idx == LVDSK_IDX_IRQ_EN) begin
        d.irq_en = pwdata[LVDSK_IRQ_W-1:0];
      end
      if (idx == LVDSK_IDX_IRQ_CLR) begin
        clr = pwdata[LVDSK_IRQ_W-1:0];
      end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    d.irq_stat = (q.irq_stat & ~clr) | evt;

    // Read data is captured in the setup phase and held through access
    if (setup_ph) begin
      d.prdata = '0;
      if (is_skew) begin
        d.prdata[7:0] = skew_hi ? q.skew[skew_lane][15:8] : q.skew[skew_lane][7:0];
      end else begin
        unique case (idx)
          LVDSK_IDX_EARLY: d.prdata[LANES-1:0] = q.early;
          LVDSK_IDX_LATE: d.prdata[LANES-1:0] = q.late_ok;
          LVDSK_IDX_SYNC: d.prdata[7:0] = q.sync_mode;
          LVDSK_IDX_MODE: d.prdata[1:0] = q.mode;
          LVDSK_IDX_IRQ_STAT: d.prdata[LVDSK_IRQ_W-1:0] = q.irq_stat;
          LVDSK_IDX_IRQ_EN: d.prdata[LVDSK_IRQ_W-1:0] = q.irq_en;
          default: d.prdata = '0;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.skew <= {LANES{LVDSK_SKEW_RST}};
      q.mode <= LVDSK_MODE_RST;
      q.sync_mode <= LVDSK_SYNC_RST;
      q.early <= LVDSK_EARLY_RST;
      q.late_ok <= LVDSK_LATE_RST;
    end else begin
      q <= d;
    end
  end

  // APB answers in the first access cycle
  assign pready = access_ph;
  assign pslverr = access_ph & ~mapped;
  assign prdata = q.prdata;

  // Outputs
  assign lane_out = q.lane_out;
  assign lane_valid = q.lane_valid;
  assign enable_out = q.enable_out;
  assign vsync_out = q.vsync_out;
  assign hsync_out = q.hsync_out;
  assign align_out = q.align_out;
  assign irq = |(q.irq_stat & q.irq_en);

endmodule

// ### logic/lvdsk_pkg.sv
// Constants and types shared by the LVDS deskew and sync-pin block
package lvdsk_pkg;

  // Lane count and sampling tap depth (16 delay settings, 0 to 15, plus one look-behind tap)
  localparam int LVDSK_LANES = 4;
  localparam int LVDSK_TAPS = 17;
  localparam int LVDSK_DLY_W = 4;
  localparam int LVDSK_SKEW_W = 16;

  // APB addressing: printed offsets are word indices, byte address is index times four
  localparam int LVDSK_ADDR_LSB = 2;
  localparam int LVDSK_IDX_W = 8;
  localparam logic [7:0] LVDSK_IDX_SKEW_BASE = 8'h22;
  localparam logic [7:0] LVDSK_IDX_SKEW_LAST = 8'h29;
  localparam logic [7:0] LVDSK_IDX_EARLY = 8'h29;
  localparam logic [7:0] LVDSK_IDX_LATE = 8'h2A;
  localparam logic [7:0] LVDSK_IDX_SYNC = 8'h2B;
  localparam logic [7:0] LVDSK_IDX_MODE = 8'h50;
  localparam logic [7:0] LVDSK_IDX_IRQ_STAT = 8'h51;
  localparam logic [7:0] LVDSK_IDX_IRQ_CLR = 8'h52;
  localparam logic [7:0] LVDSK_IDX_IRQ_EN = 8'h53;

  // Reset values
  localparam logic [15:0] LVDSK_SKEW_RST = 16'h0000;
  localparam logic [7:0] LVDSK_SYNC_RST = 8'h02;
  localparam logic [1:0] LVDSK_MODE_RST = 2'h0;
  localparam logic [3:0] LVDSK_EARLY_RST = 4'h0;
  localparam logic [3:0] LVDSK_LATE_RST = 4'hF;

  // Deskew mode value that makes the lane 0 skew setting drive every lane
  localparam logic [1:0] LVDSK_MODE_OVERRIDE = 2'h2;
  localparam logic [3:0] LVDSK_DLY_MAX = 4'hF;

  // Field positions inside sync_pin_mode
  localparam int LVDSK_EN_ROLE_LSB = 1;
  localparam int LVDSK_HS_ROLE_BIT = 3;

  // Interrupt status bits
  localparam int LVDSK_IRQ_W = 2;
  localparam int LVDSK_IRQ_EARLY = 0;
  localparam int LVDSK_IRQ_LATE = 1;

  // Role of the shared enable / vertical sync pin
  typedef enum logic [1:0] {
    LVDSK_EN_UNUSED = 2'b00,
    LVDSK_EN_ENABLE = 2'b01,
    LVDSK_EN_VSYNC = 2'b10
  } lvdsk_en_role_type;

endpackage

// ### logic/lvdsk_lane_delay.sv
// One lane: sample history and taps at the programmed delay
`timescale 1ns/1ps
module lvdsk_lane_delay
  import lvdsk_pkg::*;
#(
  parameter int TAPS = LVDSK_TAPS
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic din, // Synchronised lane sample
  input wire logic [LVDSK_DLY_W-1:0] delay, // Delay in units of one pclk cycle
  output logic smp, // Sample at the delay point
  output logic older, // Sample one unit older
  output logic newer // Sample one unit newer
);

  typedef struct packed {
    logic [TAPS-1:0] hist;
  } lvdsk_lane_state_type;

  lvdsk_lane_state_type q;
  lvdsk_lane_state_type d;

  // History shifts in one new sample each cycle; bit 0 is newest
  always_comb begin
    d = q;
    d.hist = {q.hist[TAPS-2:0], din};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Taps around the delay point; at zero delay the newer tap repeats the sample
  assign smp = q.hist[delay];
  assign older = q.hist[delay + 5'd1];
  assign newer = (delay == '0) ? q.hist[0] : q.hist[delay - 4'd1];

endmodule

// ### tb/lvdsk_deskew_checker.sv
// Port assertions for the deskew block
`timescale 1ns/1ps
module lvdsk_deskew_checker
  import lvdsk_pkg::*;
#(parameter int LANES = LVDSK_LANES) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic link_clk, // Link clock
  input wire logic [LANES-1:0] lane_out, // Lanes
  input wire logic lane_valid, // Lane strobe
  input wire logic enable_out, // Enable role
  input wire logic vsync_out, // Vsync role
  input wire logic hsync_out, // Hsync role
  input wire logic align_out, // Align role
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_track_a: assert property (pready == (psel && penable)) else $error("ready wrong");
  err_access_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
  rdata_hold_a: assert property (psel && penable |=> $stable(prdata)) else $error("read data moved");
  valid_pulse_a: assert property (lane_valid |=> !lane_valid) else $error("strobe too long");
  out_hold_a: assert property (!lane_valid |-> $stable(lane_out)) else $error("lanes moved");
  link_valid_a: assert property ($rose(link_clk) |-> ##[2:6] lane_valid) else $error("no strobe");
  pin_excl_a: assert property (!(enable_out && vsync_out)) else $error("two pin roles");
  hs_excl_a: assert property (!(hsync_out && align_out)) else $error("two hs roles");
  irq_cause_a: assert property ($rose(irq) |-> lane_valid || $past(psel && penable && pwrite))
    else $error("irq without cause");
endmodule

bind lvdsk_deskew lvdsk_deskew_checker #(.LANES(LANES)) lvdsk_deskew_checker_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .link_clk(link_clk), .lane_out(lane_out), .lane_valid(lane_valid),
  .enable_out(enable_out), .vsync_out(vsync_out), .hsync_out(hsync_out), .align_out(align_out), .irq(irq));

// ### tb/lvdsk_lane_source.sv
// Behavioural LVDS source: link clock and four lanes
`timescale 1ns/1ps
module lvdsk_lane_source (
  input wire logic run, // Send frames while high
  output logic link_clk, // Still between frames
  output logic [3:0] lane_in // Same bit on all lanes
);
  logic [7:0] n;
  // Data moves on the falling link edge; idle lanes toggle
  initial begin
    link_clk = 1'b0;
    lane_in = 4'h0;
    n = 8'h00;
    #7;
    forever begin
      #160 link_clk = run;
      #160 link_clk = 1'b0;
      n = n + 8'h01;
      lane_in = run ? {4{n[1]}} : ~lane_in;
    end
  end
endmodule

// ### tb/lvdsk_deskew_bench.sv
// Self-checking bench for the deskew block
`timescale 1ns/1ps
module lvdsk_deskew_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, run, lane_valid, irq, er;
  logic en_pin, hs_pin, enable_out, vsync_out, hsync_out, align_out, link_clk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] lane_in, lane_out;
  int mismatches, n_tests, cyc;
  lvdsk_deskew lvdsk_deskew_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .lane_in(lane_in), .enable_or_vertical_sync_pin(en_pin),
    .horizontal_sync_or_align_pin(hs_pin), .lane_out(lane_out), .lane_valid(lane_valid),
    .enable_out(enable_out), .vsync_out(vsync_out), .hsync_out(hsync_out), .align_out(align_out), .irq(irq));
  lvdsk_lane_source lvdsk_lane_source_i (.run(run), .link_clk(link_clk), .lane_in(lane_in));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; waits for pready
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_valid(input int k);
    repeat (k) begin
      @(posedge pclk);
      while (lane_valid !== 1'b1) @(posedge pclk);
    end
  endtask
  task automatic t_reset;
    for (int i = 8'h22; i <= 8'h2B; i++) begin
      apb(1'b0, 8'(i), 8'h00);
      chk("reset value", rd, i == 8'h2B ? 32'h2 : (i == 8'h2A ? 32'hF : 32'h0));
    end
    $display("reset test done");
  endtask
  task automatic t_regs;
    for (int i = 8'h22; i <= 8'h28; i++) begin
      apb(1'b1, 8'(i), 8'(i) ^ 8'hA5);
      apb(1'b0, 8'(i), 8'h00);
      chk("skew byte", rd, 32'(8'(i) ^ 8'hA5));
    end
    apb(1'b1, 8'h2A, 8'h00);
    apb(1'b0, 8'h2A, 8'h00);
    chk("late read only", rd, 32'hF);
    apb(1'b0, 8'h70, 8'h00);
    chk("unmapped", 32'(er), 32'h1);
    $display("register test done");
  endtask
  task automatic t_pins;
    en_pin <= 1'b1;
    hs_pin <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, 8'h2B, 8'(r << 1));
      repeat (6) @(posedge pclk);
      chk("enable pin", 32'(enable_out), 32'(r[1:0] == 2'h1));
      chk("vsync pin", 32'(vsync_out), 32'(r[1:0] == 2'h2));
      chk("hs pin", 32'({hsync_out, align_out}), 32'({!r[2], r[2]}));
    end
    $display("pin test done");
  endtask
  task automatic t_delay;
    logic [7:0] ix [7] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28};
    logic [7:0] vl [7] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h0F, 8'h01};
    logic [3:0] h [6];
    for (int i = 0; i < 7; i++) apb(1'b1, ix[i], vl[i]);
    run <= 1'b1;
    wait_valid(4);
    for (int m = 0; m < 6; m++) begin
      wait_valid(1);
      h[m] = lane_out;
    end
    for (int m = 2; m < 6; m++) begin
      chk("lane1 delay", 32'(h[m][1]), 32'(h[m-1][0]));
      chk("lane2 delay", 32'(h[m][2]), 32'(h[m-2][0]));
      chk("lane3 delay", 32'(h[m][3]), 32'(h[m-2][0]));
    end
    apb(1'b0, 8'h29, 8'h00);
    chk("early ok", rd, 32'h0);
    apb(1'b0, 8'h2A, 8'h00);
    chk("late ok", rd, 32'hF);
    apb(1'b1, 8'h50, 8'h02);
    wait_valid(3);
    for (int m = 0; m < 6; m++) begin
      wait_valid(1);
      chk("override", 32'(lane_out == 4'h0 || lane_out == 4'hF), 32'h1);
    end
    $display("delay test done");
  endtask
  task automatic t_irq;
    apb(1'b1, 8'h50, 8'h00);
    apb(1'b1, 8'h23, 8'h04);
    apb(1'b1, 8'h52, 8'h03);
    wait_valid(6);
    apb(1'b0, 8'h51, 8'h00);
    chk("event seen", 32'(rd != 32'h0), 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, 8'h53, 8'h03);
    run <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("irq raised", 32'(irq), 32'h1);
    apb(1'b1, 8'h52, 8'h03);
    apb(1'b0, 8'h51, 8'h00);
    chk("status cleared", rd, 32'h0);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("interrupt test done");
  endtask
  // Clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict;
    end
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, run, en_pin, hs_pin} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_pins;
    t_delay;
    t_irq;
    give_verdict;
  end
endmodule
